/* src/mifl_edge_det.sv */
// Per-bit rise and fall detector for synchronous inputs
`timescale 1ns/100ps
`default_nettype none
module mifl_edge_det #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Sampled level
    input wire logic [W-1:0] d_i,
    // Edges seen this cycle
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] prev_reg;
    logic primed_reg;

    // The first sample after reset only primes the history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_reg <= '0;
            primed_reg <= 1'b0;
        end else begin
            prev_reg <= d_i;
            primed_reg <= 1'b1;
        end
    end

    assign rise_o = primed_reg ? (d_i & ~prev_reg) : '0;
    assign fall_o = primed_reg ? (~d_i & prev_reg) : '0;
endmodule
`default_nettype wire

/* src/mifl_irq_flags.sv */
// Interrupt flags, enables, timer, sleep wake-up and Wishbone register slave
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module mifl_irq_flags #(
    parameter int PHASES = mifl_pkg::PHASES_PER_INSTR
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [mifl_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins
    input wire logic ext_irq_pin_i,
    input wire logic [mifl_pkg::PORT_W-1:0] second_port_i,
    // Processor core
    input wire logic core_sleep_i,
    output logic core_irq_o,
    output logic core_wake_o,
    output logic core_vector_o,
    // System interrupt
    output logic irq_o
);
    import mifl_pkg::*;

    localparam int CHG_W = PORT_CHG_HI - PORT_CHG_LO + 1;

    mifl_ctl_t irq_control_reg;
    logic [7:0] option_reg;
    logic [7:0] timer_count_reg;
    mifl_evt_t evt_stat_reg;
    mifl_evt_t evt_mask_reg;
    mifl_wake_state_t wake_state_reg;
    mifl_wake_state_t wake_state_next;
    logic [2:0] wake_en_reg;
    logic [31:0] rd_data_next;
    logic core_irq_next;

    logic instr_tick;
    logic ext_rise;
    logic ext_fall;
    logic [CHG_W-1:0] port_rise;
    logic [CHG_W-1:0] port_fall;
    logic edge_polarity_select;
    logic ext_edge;
    logic port_chg;
    logic timer_ovf;
    logic timer_step;
    logic wake_pending;
    logic wake_event;

    logic bus_req;
    logic wr_ctrl;
    logic wr_option;
    logic wr_timer;
    logic wr_stat;
    logic wr_mask;

    // Address match of the bus address to one register
    function automatic logic addr_hit(input logic [ADDR_W-1:0] adr,
                                      input logic [ADDR_W-1:0] reg_adr);
        addr_hit = (adr == reg_adr);
    endfunction

    // Write strobe for the low byte lane of one register
    function automatic logic wr_hit(input logic req, input logic we,
                                    input logic lane0,
                                    input logic [ADDR_W-1:0] adr,
                                    input logic [ADDR_W-1:0] reg_adr);
        wr_hit = req && we && lane0 && addr_hit(adr, reg_adr);
    endfunction

    // Instruction-cycle enable
    mifl_tick_div #(
        .DIV(PHASES)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(instr_tick)
    );

    // External pin edges
    mifl_edge_det #(
        .W(1)
    ) u_ext_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(ext_irq_pin_i),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );

    // Upper nibble changes of the second port, compared every clock
    mifl_edge_det #(
        .W(CHG_W)
    ) u_port_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(second_port_i[PORT_CHG_HI:PORT_CHG_LO]),
        .rise_o(port_rise),
        .fall_o(port_fall)
    );

    assign edge_polarity_select = option_reg[EDGE_POL_BIT];
    assign ext_edge = edge_polarity_select ? ext_rise : ext_fall;
    assign port_chg = |(port_rise | port_fall);

    // Bus decode: one request is served per ack
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl = wr_hit(bus_req, wb_we_i, wb_sel_i[0], wb_adr_i, ADDR_CTRL);
    assign wr_option = wr_hit(bus_req, wb_we_i, wb_sel_i[0], wb_adr_i, ADDR_OPTION);
    assign wr_timer = wr_hit(bus_req, wb_we_i, wb_sel_i[0], wb_adr_i, ADDR_TIMER);
    assign wr_stat = wr_hit(bus_req, wb_we_i, wb_sel_i[0], wb_adr_i, ADDR_EVT_STAT);
    assign wr_mask = wr_hit(bus_req, wb_we_i, wb_sel_i[0], wb_adr_i, ADDR_EVT_MASK);

    // Timer counts once per instruction cycle and halts in sleep
    assign timer_step = instr_tick && (wake_state_reg == WK_AWAKE) && !wr_timer;
    assign timer_ovf = timer_step && (timer_count_reg == TIMER_MAX);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_count_reg <= TIMER_RST;
        end else if (wr_timer) begin
            timer_count_reg <= wb_dat_i[7:0];
        end else if (timer_step) begin
            timer_count_reg <= timer_count_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            option_reg <= OPTION_RST;
        end else if (wr_option) begin
            option_reg <= wb_dat_i[7:0];
        end
    end

    // Flags set regardless of enables; a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_control_reg <= CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                irq_control_reg <= mifl_ctl_t'(wb_dat_i[7:0]);
                irq_control_reg.reserved <= 1'b0;
            end
            if (ext_edge) begin
                irq_control_reg.ext_pin_irq_flag <= 1'b1;
            end
            if (timer_ovf) begin
                irq_control_reg.timer_overflow_flag <= 1'b1;
            end
            if (port_chg) begin
                irq_control_reg.port_change_flag <= 1'b1;
            end
        end
    end

    // Request to the core: source flag and enable, then the global gate
    always_comb begin
        core_irq_next = irq_control_reg.global_irq_enable && (
            (irq_control_reg.ext_pin_irq_flag && irq_control_reg.ext_pin_irq_enable) ||
            (irq_control_reg.timer_overflow_flag &&
             irq_control_reg.timer_overflow_enable) ||
            (irq_control_reg.port_change_flag && irq_control_reg.port_change_enable));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_irq_o <= 1'b0;
        end else begin
            core_irq_o <= core_irq_next;
        end
    end

    // Enables captured at sleep entry decide which sources may wake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_en_reg <= 3'h0;
        end else if (wake_state_reg == WK_AWAKE && core_sleep_i) begin
            wake_en_reg <= {irq_control_reg.timer_overflow_enable,
                            irq_control_reg.ext_pin_irq_enable,
                            irq_control_reg.port_change_enable};
        end
    end

    // Flags already set (or set this cycle) with a captured enable wake the core
    assign wake_pending =
        ((irq_control_reg.ext_pin_irq_flag || ext_edge) && wake_en_reg[1]) ||
        (irq_control_reg.timer_overflow_flag && wake_en_reg[2]) ||
        ((irq_control_reg.port_change_flag || port_chg) && wake_en_reg[0]);

    always_comb begin
        wake_state_next = wake_state_reg;
        unique case (wake_state_reg)
            WK_AWAKE: begin
                if (core_sleep_i) begin
                    wake_state_next = WK_ASLEEP;
                end
            end
            WK_ASLEEP: begin
                if (!core_sleep_i) begin
                    wake_state_next = WK_AWAKE;
                end else if (wake_pending) begin
                    wake_state_next = WK_WAKING;
                end
            end
            WK_WAKING: begin
                if (!core_sleep_i) begin
                    wake_state_next = WK_AWAKE;
                end
            end
            default: begin
                wake_state_next = WK_AWAKE;
            end
        endcase
    end

    assign wake_event = (wake_state_reg == WK_ASLEEP) && core_sleep_i && wake_pending;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_state_reg <= WK_AWAKE;
        end else begin
            wake_state_reg <= wake_state_next;
        end
    end

    // Wake pulse, with the branch decision held until the next wake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_wake_o <= 1'b0;
            core_vector_o <= 1'b0;
        end else begin
            core_wake_o <= wake_event;
            if (wake_event) begin
                core_vector_o <= irq_control_reg.global_irq_enable;
            end
        end
    end

    // Event status: sticky, write one to clear, new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_stat_reg <= EVT_RST;
        end else begin
            if (wr_stat) begin
                evt_stat_reg <= evt_stat_reg & ~mifl_evt_t'(wb_dat_i[3:0]);
            end
            if (ext_edge) begin
                evt_stat_reg.ext_edge <= 1'b1;
            end
            if (timer_ovf) begin
                evt_stat_reg.timer_ovf <= 1'b1;
            end
            if (port_chg) begin
                evt_stat_reg.port_chg <= 1'b1;
            end
            if (wake_event) begin
                evt_stat_reg.wake <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_mask_reg <= EVT_RST;
        end else if (wr_mask) begin
            evt_mask_reg <= mifl_evt_t'(wb_dat_i[3:0]);
        end
    end

    assign irq_o = |(evt_stat_reg & evt_mask_reg);

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_data_next = 32'h0000_0000;
        if (addr_hit(wb_adr_i, ADDR_CTRL)) begin
            rd_data_next[7:0] = irq_control_reg;
        end else if (addr_hit(wb_adr_i, ADDR_OPTION)) begin
            rd_data_next[7:0] = option_reg;
        end else if (addr_hit(wb_adr_i, ADDR_TIMER)) begin
            rd_data_next[7:0] = timer_count_reg;
        end else if (addr_hit(wb_adr_i, ADDR_PORT)) begin
            rd_data_next[PORT_W-1:0] = second_port_i;
        end else if (addr_hit(wb_adr_i, ADDR_EVT_STAT)) begin
            rd_data_next[3:0] = evt_stat_reg;
        end else if (addr_hit(wb_adr_i, ADDR_EVT_MASK)) begin
            rd_data_next[3:0] = evt_mask_reg;
        end
    end

    // One wait state: ack follows the request by one edge and drops after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_data_next;
            end
        end
    end

endmodule
`default_nettype wire

/* src/mifl_pkg.sv */
// Constants, field layouts and types of the interrupt flag logic
package mifl_pkg;

    // Register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_OPTION = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TIMER = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PORT = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 8'h14;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'h00;
    localparam logic [7:0] TIMER_RST = 8'h00;
    localparam logic [3:0] EVT_RST = 4'h0;

    // Field positions and timer limits
    localparam int EDGE_POL_BIT = 6;
    localparam logic [7:0] TIMER_MAX = 8'hFF;
    localparam int PORT_W = 8;
    localparam int PORT_CHG_LO = 4;
    localparam int PORT_CHG_HI = 7;

    // One instruction cycle spans four clock phases
    localparam int PHASES_PER_INSTR = 4;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic global_irq_enable;
        logic reserved;
        logic timer_overflow_enable;
        logic ext_pin_irq_enable;
        logic port_change_enable;
        logic timer_overflow_flag;
        logic ext_pin_irq_flag;
        logic port_change_flag;
    } mifl_ctl_t;

    // Event status and mask layout, bit 3 down to bit 0
    typedef struct packed {
        logic wake;
        logic timer_ovf;
        logic ext_edge;
        logic port_chg;
    } mifl_evt_t;

    typedef enum logic [1:0] {
        WK_AWAKE = 2'b00,
        WK_ASLEEP = 2'b01,
        WK_WAKING = 2'b11
    } mifl_wake_state_t;

endpackage

/* src/mifl_tick_div.sv */
// Divider that issues a one-cycle enable pulse every DIV clocks
`timescale 1ns/100ps
`default_nettype none
module mifl_tick_div #(
    parameter int DIV = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Enable pulse
    output logic tick_o
);
    logic [$clog2(DIV)-1:0] cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt_reg == ($clog2(DIV))'(DIV - 1));
            if (cnt_reg == ($clog2(DIV))'(DIV - 1)) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/mifl_core_model.sv */
// Behavioural processor core that sleeps on command and leaves sleep on a wake pulse
`timescale 1ns/100ps
`default_nettype none
module mifl_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench commands
    input wire logic go_sleep_i,
    input wire logic leave_i,
    // From the interrupt logic
    input wire logic wake_i,
    input wire logic vector_i,
    // Core state
    output logic sleep_o,
    output logic vector_taken_o,
    output logic [7:0] wakes_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_o <= 1'b0;
            vector_taken_o <= 1'b0;
            wakes_o <= 8'h00;
        end else if (wake_i && sleep_o) begin
            sleep_o <= 1'b0;
            vector_taken_o <= vector_i;
            wakes_o <= wakes_o + 8'h01;
        end else if (leave_i) begin
            sleep_o <= 1'b0;
        end else if (go_sleep_i) begin
            sleep_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/mifl_irq_flags_chk.sv */
// Port-level assertion checker for the interrupt flag logic, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module mifl_irq_flags_chk
    import mifl_pkg::*;
#(
    parameter int PHASES = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [mifl_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins
    input wire logic ext_irq_pin_i,
    input wire logic [mifl_pkg::PORT_W-1:0] second_port_i,
    // Processor core and system interrupt
    input wire logic core_sleep_i,
    input wire logic core_irq_o,
    input wire logic core_wake_o,
    input wire logic core_vector_o,
    input wire logic irq_o
);
    mifl_ctl_t ctl_reg;
    logic pol_reg;
    logic [3:0] mask_reg;
    logic take;
    logic en_any;
    logic unmapped;

    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign unmapped = !(wb_adr_i inside {ADDR_CTRL, ADDR_OPTION, ADDR_TIMER, ADDR_PORT,
        ADDR_EVT_STAT, ADDR_EVT_MASK});
    assign en_any = ctl_reg.global_irq_enable && (ctl_reg.timer_overflow_enable
        || ctl_reg.ext_pin_irq_enable || ctl_reg.port_change_enable);

    // Shadow of the software-written enables, polarity and mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg <= '0;
            pol_reg <= 1'b0;
            mask_reg <= 4'h0;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == ADDR_CTRL) ctl_reg <= mifl_ctl_t'(wb_dat_i[7:0]);
            if (wb_adr_i == ADDR_OPTION) pol_reg <= wb_dat_i[EDGE_POL_BIT];
            if (wb_adr_i == ADDR_EVT_MASK) mask_reg <= wb_dat_i[3:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ext_edge;
        ctl_reg.global_irq_enable && ctl_reg.ext_pin_irq_enable && !wb_cyc_i
            && (pol_reg ? $rose(ext_irq_pin_i) : $fell(ext_irq_pin_i));
    endsequence
    sequence s_port_chg;
        ctl_reg.global_irq_enable && ctl_reg.port_change_enable && !wb_cyc_i
            && $changed(second_port_i[PORT_CHG_HI:PORT_CHG_LO]);
    endsequence

    property p_ack_next; take |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_unmapped; take && !wb_we_i && unmapped |=> wb_dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ext_irq; s_ext_edge |-> ##[1:4] core_irq_o; endproperty
    a_ext_irq: assert property (p_ext_irq) else $error("pin edge gave no request");
    property p_port_irq; s_port_chg |-> ##[1:4] core_irq_o; endproperty
    a_port_irq: assert property (p_port_irq) else $error("port change gave no request");
    property p_gated; !en_any && !$past(en_any) |-> !core_irq_o; endproperty
    a_gated: assert property (p_gated) else $error("request while disabled");
    property p_masked; mask_reg == 4'h0 |-> !irq_o; endproperty
    a_masked: assert property (p_masked) else $error("interrupt with empty mask");
    property p_wake_pulse; core_wake_o |=> !core_wake_o; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
    property p_wake_asleep; core_wake_o |-> $past(core_sleep_i); endproperty
    a_wake_asleep: assert property (p_wake_asleep) else $error("wake while awake");
    property p_vector; core_wake_o |-> core_vector_o == ctl_reg.global_irq_enable; endproperty
    a_vector: assert property (p_vector) else $error("vector choice wrong");
endmodule

bind mifl_irq_flags mifl_irq_flags_chk #(.PHASES(PHASES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_irq_pin_i(ext_irq_pin_i), .second_port_i(second_port_i),
    .core_sleep_i(core_sleep_i), .core_irq_o(core_irq_o), .core_wake_o(core_wake_o),
    .core_vector_o(core_vector_o), .irq_o(irq_o));
`default_nettype wire

/* tb/mifl_irq_flags_tb_top.sv */
// Self-checking testbench of the interrupt flag logic
`timescale 1ns/100ps
`default_nettype none
module mifl_irq_flags_tb_top;
    import mifl_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, pin, go, leave;
    logic [7:0] adr, port;
    logic [3:0] sel;
    logic [31:0] dat;
    wire logic [31:0] dat_o;
    wire logic [7:0] wakes;
    wire logic ack, sleep, irq, wake, vec, vec_taken, irq_o;
    int err_total, checks_done;

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    mifl_irq_flags #(.PHASES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_irq_pin_i(pin), .second_port_i(port),
        .core_sleep_i(sleep), .core_irq_o(irq), .core_wake_o(wake), .core_vector_o(vec),
        .irq_o(irq_o));
    mifl_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .go_sleep_i(go), .leave_i(leave),
        .wake_i(wake), .vector_i(vec), .sleep_o(sleep), .vector_taken_o(vec_taken),
        .wakes_o(wakes));

    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            $display("unexpected at %0t no ack got %h exp %h", $time, 1'b0, 1'b1);
        end
        r = dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, a, {24'h0, d}, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(r & {24'hFFFFFF, m}, {24'h0, e});
    endtask

    task automatic t_regs();
        rd(ADDR_CTRL, 8'hFF, CTRL_RST);
        rd(ADDR_OPTION, 8'hFF, OPTION_RST);
        rd(ADDR_EVT_STAT, 8'hFF, 8'h00);
        rd(ADDR_EVT_MASK, 8'hFF, 8'h00);
        rd(ADDR_PORT, 8'hFF, 8'h00);
        wr(ADDR_OPTION, 8'hC5);
        rd(ADDR_OPTION, 8'hFF, 8'hC5);
        wr(ADDR_CTRL, 8'h40);
        rd(ADDR_CTRL, 8'hFB, 8'h00);
        wr(8'h18, 8'hFF);
        rd(8'h18, 8'hFF, 8'h00);
    endtask
    task automatic t_ext();
        logic pol;
        for (int p = 1; p >= 0; p--) begin
            pol = p[0];
            wr(ADDR_OPTION, pol ? 8'h40 : 8'h00);
            @(posedge clk_i) pin <= pol;
            repeat (3) @(posedge clk_i);
            wr(ADDR_CTRL, 8'h00);
            @(posedge clk_i) pin <= ~pol;
            repeat (3) @(posedge clk_i);
            rd(ADDR_CTRL, 8'hFB, 8'h00);
            @(posedge clk_i) pin <= pol;
            repeat (3) @(posedge clk_i);
            rd(ADDR_CTRL, 8'hFB, 8'h02);
            wr(ADDR_CTRL, 8'h92);
            repeat (3) @(posedge clk_i);
            chk(irq, 1'b1);
            wr(ADDR_CTRL, 8'h82);
            repeat (3) @(posedge clk_i);
            chk(irq, 1'b0);
            rd(ADDR_CTRL, 8'hFB, 8'h82);
            wr(ADDR_CTRL, 8'h00);
        end
    endtask
    task automatic t_port();
        wr(ADDR_CTRL, 8'h88);
        for (int b = 0; b < 8; b++) begin
            @(posedge clk_i) port[b] <= ~port[b];
            repeat (4) @(posedge clk_i);
            chk(irq, b >= 4);
            rd(ADDR_PORT, 8'hFF, port);
            rd(ADDR_CTRL, 8'h01, {7'h0, b >= 4});
            wr(ADDR_CTRL, 8'h88);
        end
        wr(ADDR_CTRL, 8'h00);
    endtask
    task automatic t_timer();
        logic [31:0] r;
        int n;
        wr(ADDR_TIMER, 8'hFD);
        wr(ADDR_CTRL, 8'hA0);
        n = 0;
        do begin
            wb(1'b0, ADDR_CTRL, 32'h0, r);
            n++;
        end while (r[2] !== 1'b1 && n < 20);
        chk(r, 32'hA4);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'b1);
        wr(ADDR_CTRL, 8'h84);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b0);
        wr(ADDR_TIMER, 8'h00);
        wr(ADDR_CTRL, 8'h00);
    endtask
    task automatic t_events();
        rd(ADDR_EVT_STAT, 8'h03, 8'h03);
        chk(irq_o, 1'b0);
        wr(ADDR_EVT_MASK, 8'h02);
        @(posedge clk_i);
        chk(irq_o, 1'b1);
        wr(ADDR_EVT_STAT, 8'h02);
        @(posedge clk_i);
        chk(irq_o, 1'b0);
        rd(ADDR_EVT_STAT, 8'h03, 8'h01);
        wr(ADDR_EVT_STAT, 8'h0F);
        wr(ADDR_EVT_MASK, 8'h00);
    endtask
    task automatic t_sleep(input logic [7:0] ctl, input logic late, input logic ew,
        input logic ev);
        logic [7:0] w0;
        wr(ADDR_OPTION, 8'h40);
        @(posedge clk_i) pin <= 1'b0;
        wr(ADDR_CTRL, ctl);
        w0 = wakes;
        @(posedge clk_i) go <= 1'b1;
        @(posedge clk_i) go <= 1'b0;
        repeat (3) @(posedge clk_i);
        if (late) wr(ADDR_CTRL, 8'h10);
        @(posedge clk_i) pin <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk(wakes - w0, {7'h0, ew});
        if (ew) chk(vec_taken, ev);
        rd(ADDR_EVT_STAT, 8'h08, ew ? 8'h08 : 8'h00);
        @(posedge clk_i) leave <= 1'b1;
        @(posedge clk_i) leave <= 1'b0;
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_EVT_STAT, 8'h0F);
    endtask

    initial begin
        {cyc, stb, we, pin, go, leave, adr, port, sel, dat} = '0;
        err_total = 0;
        checks_done = 0;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_ext();
        t_port();
        t_timer();
        t_events();
        t_sleep(8'h10, 1'b0, 1'b1, 1'b0);
        t_sleep(8'h90, 1'b0, 1'b1, 1'b1);
        t_sleep(8'h00, 1'b1, 1'b0, 1'b0);
        results();
    end
    // Cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        results();
    end
endmodule
`default_nettype wire
